/* include/dtg_pkg.sv */
package dtg_pkg;

   // register bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
   localparam logic [7:0] ADDR_TIMER_ZERO_COUNT = 8'h8A;
   localparam logic [7:0] ADDR_TIMER_ONE_COUNT = 8'h8B;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h8C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h8D;
   localparam logic [7:0] ADDR_SERVICE_ACK = 8'h8E;

   // timer control bit positions
   localparam int BIT_TIMER_ZERO_OVERFLOW_FLAG = 5;
   localparam int BIT_TIMER_ZERO_RUN = 4;
   localparam int BIT_EXT_IRQ_ONE_FLAG = 3;
   localparam int BIT_EXT_IRQ_ONE_TYPE = 2;
   localparam int BIT_EXT_IRQ_ZERO_FLAG = 1;
   localparam int BIT_EXT_IRQ_ZERO_TYPE = 0;
   localparam int BIT_TIMER_ONE_RUN = 6;

   // timer mode control bit positions
   localparam int BIT_GATE_ONE = 7;
   localparam int BIT_SOURCE_ONE = 6;
   localparam int BIT_GATE_ZERO = 3;
   localparam int BIT_SOURCE_ZERO = 2;

   // service acknowledge bit positions
   localparam int BIT_ACK_TIMER_ZERO = 0;
   localparam int BIT_ACK_EXT_ZERO = 1;
   localparam int BIT_ACK_EXT_ONE = 2;

   // interrupt status bit positions
   localparam int BIT_EV_TIMER_ZERO = 0;
   localparam int BIT_EV_EXT_ZERO = 1;
   localparam int BIT_EV_EXT_ONE = 2;
   localparam int BIT_EV_TIMER_ONE = 3;

   // reset values and counter maximum
   localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RESET_TIMER_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RESET_COUNT = 8'h00;
   localparam logic [3:0] RESET_IRQ = 4'h0;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [1:0] SYNC_RESET = 2'h3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtg_bus_req_t;

   typedef struct packed {
      logic [1:0] ext_zero_sync;
      logic [1:0] ext_one_sync;
      logic [1:0] count_zero_sync;
      logic [1:0] count_one_sync;
      logic ext_zero_prev;
      logic ext_one_prev;
      logic count_zero_prev;
      logic count_one_prev;
      logic [7:0] timer_control;
      logic [7:0] timer_mode_control;
      logic [7:0] count_zero;
      logic [7:0] count_one;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic [7:0] rdata;
      logic irq;
   } dtg_state_t;

endpackage

/* src/dtg_timer_gate.sv */
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - timer zero sets its overflow flag whenever its count rolls over from the maximum.
// - the overflow flag clears on entry to the timer-zero service routine and software may set or clear it.
// - each timer counts only while its run bit is one; the timer-zero run bit is bit 4.
// - the external-interrupt-one flag sets on the selected falling edge or low level of its pin.
// - the external-interrupt-zero flag sets on the selected falling edge or low level of its pin.
// - an external interrupt flag clears on vectoring only when that input is edge triggered.
// - in level mode an external interrupt flag follows the inverse of its pin rather than latching.
// - one type bit per external input selects edge or level, at bits 2 and 0.
// - with the timer-one gate set, timer one runs only while its interrupt pin is high and its run bit set.
// - with the timer-one gate clear, the interrupt pin is ignored and the run bit alone enables timer one.
// - with the timer-zero gate set, timer zero needs its interrupt pin high and run bit set, else run bit only.
// - timer one counts clock cycles when its source bit is clear and falling count-pin edges when set.
// - timer zero counts clock cycles when its source bit is clear and falling count-pin edges when set.
// - the mode register holds gate, source and two mode bits for timer one high and timer zero low.
module dtg_timer_gate
   import dtg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic count_input_zero_pin,
   input wire logic count_input_one_pin,
   output logic irq,
   output logic ext_irq_zero_flag,
   output logic ext_irq_one_flag,
   output logic timer_zero_overflow_flag
);

   dtg_state_t st;
   dtg_state_t next_st;
   dtg_bus_req_t req;

   logic ez;
   logic e1;
   logic cz;
   logic c1;
   logic gate_ok_zero;
   logic gate_ok_one;
   logic tick_zero;
   logic tick_one;
   logic fall_ext_zero;
   logic fall_ext_one;
   logic wr_ctl;
   logic ack_wr;
   logic [3:0] events;

   ////////////////////////////////////////////////////////////////////////////
   // input qualification

   always_comb
   begin
      req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
      ez = st.ext_zero_sync[1];
      e1 = st.ext_one_sync[1];
      cz = st.count_zero_sync[1];
      c1 = st.count_one_sync[1];
      fall_ext_zero = st.ext_zero_prev & ~ez;
      fall_ext_one = st.ext_one_prev & ~e1;
      // gate term: pin high required only when gate bit set
      gate_ok_one = ~st.timer_mode_control[BIT_GATE_ONE] | e1;
      gate_ok_zero = ~st.timer_mode_control[BIT_GATE_ZERO] | ez;
      tick_zero = st.timer_control[BIT_TIMER_ZERO_RUN] & gate_ok_zero
         & (st.timer_mode_control[BIT_SOURCE_ZERO] ? (st.count_zero_prev & ~cz) : 1'b1);
      tick_one = st.timer_control[BIT_TIMER_ONE_RUN] & gate_ok_one
         & (st.timer_mode_control[BIT_SOURCE_ONE] ? (st.count_one_prev & ~c1) : 1'b1);
      wr_ctl = req.wr && req.addr == ADDR_TIMER_CONTROL;
      ack_wr = req.wr && req.addr == ADDR_SERVICE_ACK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      next_st = st;
      events = 4'h0;
      // two-stage synchronisers, first stage read only by the second
      next_st.ext_zero_sync = {st.ext_zero_sync[0], ext_irq_zero_pin};
      next_st.ext_one_sync = {st.ext_one_sync[0], ext_irq_one_pin};
      next_st.count_zero_sync = {st.count_zero_sync[0], count_input_zero_pin};
      next_st.count_one_sync = {st.count_one_sync[0], count_input_one_pin};
      next_st.ext_zero_prev = ez;
      next_st.ext_one_prev = e1;
      next_st.count_zero_prev = cz;
      next_st.count_one_prev = c1;

      // software writes first; hardware sets below win over them
      if (wr_ctl)
         next_st.timer_control = req.wdata;
      if (req.wr && req.addr == ADDR_TIMER_MODE_CONTROL)
         next_st.timer_mode_control = req.wdata;
      if (req.wr && req.addr == ADDR_IRQ_MASK)
         next_st.irq_mask = req.wdata[3:0];
      if (req.wr && req.addr == ADDR_IRQ_STATUS)
         next_st.irq_status = st.irq_status & ~req.wdata[3:0];

      // service routine entry clears timer zero flag, and edge-mode ext flags
      if (ack_wr && req.wdata[BIT_ACK_TIMER_ZERO])
         next_st.timer_control[BIT_TIMER_ZERO_OVERFLOW_FLAG] = 1'b0;
      if (ack_wr && req.wdata[BIT_ACK_EXT_ZERO] && st.timer_control[BIT_EXT_IRQ_ZERO_TYPE])
         next_st.timer_control[BIT_EXT_IRQ_ZERO_FLAG] = 1'b0;
      if (ack_wr && req.wdata[BIT_ACK_EXT_ONE] && st.timer_control[BIT_EXT_IRQ_ONE_TYPE])
         next_st.timer_control[BIT_EXT_IRQ_ONE_FLAG] = 1'b0;

      // counters
      if (req.wr && req.addr == ADDR_TIMER_ZERO_COUNT)
         next_st.count_zero = req.wdata;
      else if (tick_zero)
         next_st.count_zero = st.count_zero + 8'h01;
      if (req.wr && req.addr == ADDR_TIMER_ONE_COUNT)
         next_st.count_one = req.wdata;
      else if (tick_one)
         next_st.count_one = st.count_one + 8'h01;

      if (tick_zero && st.count_zero == COUNT_MAX)
      begin
         next_st.timer_control[BIT_TIMER_ZERO_OVERFLOW_FLAG] = 1'b1;
         events[BIT_EV_TIMER_ZERO] = 1'b1;
      end
      if (tick_one && st.count_one == COUNT_MAX)
         events[BIT_EV_TIMER_ONE] = 1'b1;

      // type one = falling edge latched, zero = low level followed
      if (next_st.timer_control[BIT_EXT_IRQ_ZERO_TYPE])
      begin
         if (fall_ext_zero)
         begin
            next_st.timer_control[BIT_EXT_IRQ_ZERO_FLAG] = 1'b1;
            events[BIT_EV_EXT_ZERO] = 1'b1;
         end
      end
      else
      begin
         next_st.timer_control[BIT_EXT_IRQ_ZERO_FLAG] = ~ez;
         events[BIT_EV_EXT_ZERO] = fall_ext_zero;
      end
      if (next_st.timer_control[BIT_EXT_IRQ_ONE_TYPE])
      begin
         if (fall_ext_one)
         begin
            next_st.timer_control[BIT_EXT_IRQ_ONE_FLAG] = 1'b1;
            events[BIT_EV_EXT_ONE] = 1'b1;
         end
      end
      else
      begin
         next_st.timer_control[BIT_EXT_IRQ_ONE_FLAG] = ~e1;
         events[BIT_EV_EXT_ONE] = fall_ext_one;
      end

      next_st.irq_status = next_st.irq_status | events;
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);

      // read data, one cycle after the strobe
      next_st.rdata = 8'h00;
      if (req.rd)
      begin
         unique case (req.addr)
            ADDR_TIMER_CONTROL: next_st.rdata = st.timer_control;
            ADDR_TIMER_MODE_CONTROL: next_st.rdata = st.timer_mode_control;
            ADDR_TIMER_ZERO_COUNT: next_st.rdata = st.count_zero;
            ADDR_TIMER_ONE_COUNT: next_st.rdata = st.count_one;
            ADDR_IRQ_STATUS: next_st.rdata = {4'h0, st.irq_status};
            ADDR_IRQ_MASK: next_st.rdata = {4'h0, st.irq_mask};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '{ext_zero_sync: SYNC_RESET, ext_one_sync: SYNC_RESET,
                 count_zero_sync: SYNC_RESET, count_one_sync: SYNC_RESET,
                 ext_zero_prev: 1'b1, ext_one_prev: 1'b1,
                 count_zero_prev: 1'b1, count_one_prev: 1'b1,
                 timer_control: RESET_TIMER_CONTROL,
                 timer_mode_control: RESET_TIMER_MODE_CONTROL,
                 count_zero: RESET_COUNT, count_one: RESET_COUNT,
                 irq_status: RESET_IRQ, irq_mask: RESET_IRQ,
                 rdata: 8'h00, irq: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb
   begin
      bus_rdata = st.rdata;
      irq = st.irq;
      ext_irq_zero_flag = st.timer_control[BIT_EXT_IRQ_ZERO_FLAG];
      ext_irq_one_flag = st.timer_control[BIT_EXT_IRQ_ONE_FLAG];
      timer_zero_overflow_flag = st.timer_control[BIT_TIMER_ZERO_OVERFLOW_FLAG];
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   a_overflow_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tick_zero && st.count_zero == 8'hFF && !ack_wr && !(bus_wr && bus_addr == ADDR_TIMER_ZERO_COUNT)
      |=> timer_zero_overflow_flag && st.count_zero == 8'h00)
      else $error("overflow flag not set on rollover");
   a_stopped_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !st.timer_control[4] && !(bus_wr && bus_addr == ADDR_TIMER_ZERO_COUNT) |=> $stable(st.count_zero))
      else $error("timer zero moved while stopped");
   a_gate_one_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st.timer_mode_control[7] && !e1 |-> !tick_one)
      else $error("timer one ran with gate pin low");
   a_gate_zero_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !st.timer_mode_control[3] && !st.timer_mode_control[2] && st.timer_control[4] |-> tick_zero)
      else $error("ungated timer zero not counting");
   a_level_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !st.timer_control[0] && !wr_ctl |=> ext_irq_zero_flag == ~$past(ez))
      else $error("level flag not following pin");
   a_edge_sets_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st.timer_control[2] && fall_ext_one && !wr_ctl |=> ext_irq_one_flag ##0 st.irq_status[2])
      else $error("edge flag one not set");
   a_edge_ack_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ack_wr && bus_wdata[1] && st.timer_control[0] && !fall_ext_zero && !wr_ctl |=> !ext_irq_zero_flag)
      else $error("edge flag zero not cleared by ack");
   a_counter_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st.timer_mode_control[2] && !(st.count_zero_prev && !cz) |-> !tick_zero)
      else $error("counter advanced without pin edge");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
      irq == |(st.irq_status & st.irq_mask))
      else $error("irq output disagrees with status");

   c_overflow: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(timer_zero_overflow_flag));
   c_edge_zero: cover property (@(posedge clk_sys) disable iff (!reset_n) st.timer_control[0] && fall_ext_zero);
   c_gated_count: cover property (@(posedge clk_sys) disable iff (!reset_n) st.timer_mode_control[7] && tick_one);
   c_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(irq));

endmodule
`default_nettype wire

/* bench/dtg_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////
// far side: open pins idle high, held low on request or pulsed low for two cycles
// pin order: 0 ext irq zero, 1 ext irq one, 2 count zero, 3 count one
module dtg_pin_model
   import dtg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [3:0] hold_low,
   input wire logic [3:0] pulse,
   output logic [3:0] pins
);
   logic [3:0] low_a;
   logic [3:0] low_b;

   always_ff @(posedge clk_sys)
   begin
      low_a <= pulse;
      low_b <= low_a;
   end

   // a low of two full cycles gives the synchroniser one clean falling edge
   assign pins = ~(hold_low | low_a | low_b);
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import dtg_pkg::*;
   logic clk_sys, reset_n, bus_wr, bus_rd, irq, fz, fo, fov;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, rd_val;
   logic [3:0] hold_low, pulse, pins;
   int bad_count, n_compared;

   dtg_timer_gate i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_irq_zero_pin(pins[0]),
      .ext_irq_one_pin(pins[1]), .count_input_zero_pin(pins[2]), .count_input_one_pin(pins[3]),
      .irq(irq), .ext_irq_zero_flag(fz), .ext_irq_one_flag(fo), .timer_zero_overflow_flag(fov));
   dtg_pin_model i_pins (.clk_sys(clk_sys), .hold_low(hold_low), .pulse(pulse), .pins(pins));

   ////////////////////////////////////////////////////////////////
   task tick(input int n);
      // ends off the sampling edge so outputs are settled when looked at
      repeat (n) @(negedge clk_sys);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      @(negedge clk_sys);
      rd_val = bus_rdata;
   endtask
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk8(rd_val, exp);
   endtask
   task pls(input logic [3:0] m);
      @(posedge clk_sys);
      pulse <= m;
      @(posedge clk_sys);
      pulse <= 4'h0;
      tick(3);
   endtask

   ////////////////////////////////////////////////////////////////
   task t_regs;
      chk_rd(ADDR_TIMER_CONTROL, 8'h00);
      chk_rd(ADDR_TIMER_MODE_CONTROL, 8'h00);
      wr(ADDR_TIMER_MODE_CONTROL, 8'hA5);
      chk_rd(ADDR_TIMER_MODE_CONTROL, 8'hA5);
      wr(ADDR_TIMER_MODE_CONTROL, 8'h00);
      wr(8'h80, 8'hFF);
      chk_rd(8'h80, 8'h00);
   endtask
   task t_gate;
      wr(ADDR_TIMER_ZERO_COUNT, 8'h00);
      wr(ADDR_TIMER_ONE_COUNT, 8'h00);
      wr(ADDR_TIMER_MODE_CONTROL, 8'h88);
      hold_low <= 4'h3;
      tick(4);
      wr(ADDR_TIMER_CONTROL, 8'h50);
      tick(10);
      chk_rd(ADDR_TIMER_ZERO_COUNT, 8'h00);
      chk_rd(ADDR_TIMER_ONE_COUNT, 8'h00);
      chk1(fz, 1'b1);
      wr(ADDR_TIMER_MODE_CONTROL, 8'h00);
      tick(5);
      rd(ADDR_TIMER_ZERO_COUNT);
      chk1(rd_val != 8'h00, 1'b1);
      rd(ADDR_TIMER_ONE_COUNT);
      chk1(rd_val != 8'h00, 1'b1);
      hold_low <= 4'h0;
      wr(ADDR_TIMER_CONTROL, 8'h00);
      tick(6);
      chk1(fz, 1'b0);
   endtask
   task t_source;
      wr(ADDR_TIMER_ZERO_COUNT, 8'h00);
      wr(ADDR_TIMER_ONE_COUNT, 8'h00);
      wr(ADDR_TIMER_MODE_CONTROL, 8'h44);
      wr(ADDR_TIMER_CONTROL, 8'h50);
      tick(4);
      chk_rd(ADDR_TIMER_ZERO_COUNT, 8'h00);
      repeat (3) pls(4'hC);
      tick(4);
      chk_rd(ADDR_TIMER_ZERO_COUNT, 8'h03);
      chk_rd(ADDR_TIMER_ONE_COUNT, 8'h03);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      pls(4'hC);
      tick(4);
      chk_rd(ADDR_TIMER_ZERO_COUNT, 8'h03);
      wr(ADDR_TIMER_MODE_CONTROL, 8'h00);
   endtask
   task t_overflow;
      wr(ADDR_IRQ_STATUS, 8'h0F);
      wr(ADDR_TIMER_ZERO_COUNT, 8'hFE);
      wr(ADDR_TIMER_CONTROL, 8'h10);
      tick(6);
      chk1(fov, 1'b1);
      chk_rd(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_TIMER_CONTROL, 8'h20);
      wr(ADDR_SERVICE_ACK, 8'h01);
      tick(2);
      chk1(fov, 1'b0);
      wr(ADDR_TIMER_CONTROL, 8'h20);
      tick(2);
      chk1(fov, 1'b1);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      tick(2);
      chk1(fov, 1'b0);
   endtask
   task t_ext;
      wr(ADDR_TIMER_CONTROL, 8'h05);
      pls(4'h3);
      tick(4);
      chk1(fz, 1'b1);
      chk1(fo, 1'b1);
      chk_rd(ADDR_TIMER_CONTROL, 8'h0F);
      wr(ADDR_SERVICE_ACK, 8'h06);
      tick(2);
      chk1(fz, 1'b0);
      chk1(fo, 1'b0);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      hold_low <= 4'h3;
      tick(6);
      chk1(fo, 1'b1);
      wr(ADDR_SERVICE_ACK, 8'h06);
      tick(2);
      chk1(fz, 1'b1);
      chk1(fo, 1'b1);
      hold_low <= 4'h0;
      tick(6);
      chk1(fo, 1'b0);
   endtask
   // mid-run reset must bring registers and flags back to their reset values
   task t_reset;
      wr(ADDR_TIMER_MODE_CONTROL, 8'hA5);
      wr(ADDR_TIMER_CONTROL, 8'h20);
      tick(1);
      chk1(fov, 1'b1);
      reset_n <= 1'b0;
      tick(2);
      chk1(fov, 1'b0);
      reset_n <= 1'b1;
      tick(2);
      chk_rd(ADDR_TIMER_MODE_CONTROL, 8'h00);
      chk_rd(ADDR_TIMER_CONTROL, 8'h00);
   endtask
   task t_irq;
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_IRQ_STATUS, 8'h0F);
      chk_rd(ADDR_IRQ_STATUS, 8'h00);
      pls(4'h1);
      tick(4);
      chk_rd(ADDR_IRQ_STATUS, 8'h02);
      chk1(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h02);
      tick(2);
      chk1(irq, 1'b1);
      wr(ADDR_IRQ_STATUS, 8'h02);
      tick(2);
      chk1(irq, 1'b0);
      chk_rd(ADDR_IRQ_STATUS, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial
   begin
      reset_n = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      hold_low = 4'h0;
      pulse = 4'h0;
      bad_count = 0;
      n_compared = 0;
      tick(20);
      reset_n <= 1'b1;
      t_regs;
      t_gate;
      t_source;
      t_overflow;
      t_ext;
      t_irq;
      t_reset;
      tally_and_finish;
   end

   // the tests need well under a thousand cycles
   initial
   begin
      #250000;
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
